/* verilog/phyirq_top.sv */
// Operation
// - Source flags: bit7 energy, 6 neg done, 5 fault, 4 link down, 3 ack, 2, 1.
// - Each flag is read-only and stays set until the register is read.
// - Link-down flag after reset equals the line's link-down state then.
// - Mask low byte read/write, resets zero, one enables that source.
// - Mask high byte reads zero; master writes zeros and ignores it.
// - Status bit 12 reads one once negotiation is done while negotiation is enabled, else zero.
// - Status bits 4:2: 001 10H, 101 10F, 010 100H, 110 100F.
// - Speed field after reset follows the negotiation result, not a constant.
// - Status bits 11:5 read/write, reset 0000010; master writes that pattern.
// - Energy-present drops after 256 ms without valid line energy.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps

module phyirq_top #(
    parameter longint ENERGY_TMO_CYC = phyirq_pkg::ENERGY_TMO_CYC,
    parameter int     TMO_W          = 26
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    input  wire phyirq_pkg::phyirq_events_t line_i,
    input  wire logic                       neg_enabled_i,
    output logic                            energy_present_o,
    output logic                            irq_o
);


    // All state of the block in one record
    typedef struct packed {
        phyirq_pkg::phyirq_events_t s1;
        phyirq_pkg::phyirq_events_t s2;
        phyirq_pkg::phyirq_events_t s3;
        phyirq_pkg::phyirq_events_t prev;
        logic                       first;
        logic [1:0]                 warm;
        logic [7:1]                 flags;
        logic [7:0]                 mask;
        logic [6:0]                 keep;
        logic                       autodone;
        logic [2:0]                 spd;
        logic                       energy;
        logic [TMO_W-1:0]           tmo;
        phyirq_pkg::phyirq_bus_t    bus;
        logic                       ack;
        logic [31:0]                dat;
        logic                       irq;
    } phyirq_state_t;

    phyirq_state_t              st_r;
    phyirq_state_t              st_nxt;

    phyirq_pkg::phyirq_events_t ev;
    logic                       settled;
    logic [4:0]                 idx;
    logic                       req;
    logic                       rd_req;
    logic                       wr_req;
    logic                       hit_flags;
    logic                       hit_mask;
    logic                       hit_status;
    logic [6:1]                 lvl_now;
    logic [6:1]                 lvl_old;
    logic [6:1]                 rise_v;
    logic                       energy_rise;
    logic [7:1]                 set_v;
    logic [15:0]                rd_v;
    logic                       tmo_end;

    // Synced line levels count once stages two and three agree
    assign settled = (st_r.s2 == st_r.s3);

    assign ev = settled ? st_r.s3 : st_r.prev;

    // Request decode
    assign idx = wb_adr_i[phyirq_pkg::ADDR_LSB +: 5];

    assign req = wb_cyc_i
               && wb_stb_i
               && (st_r.bus == phyirq_pkg::BUS_IDLE);

    assign rd_req = req && !wb_we_i;

    assign wr_req = req && wb_we_i;

    assign hit_flags = (idx == phyirq_pkg::IDX_SOURCE_FLAGS);

    assign hit_mask = (idx == phyirq_pkg::IDX_ENABLE_MASK);

    assign hit_status = (idx == phyirq_pkg::IDX_NEG_STATUS);

    // Event levels, link down taken as the inverse of link up
    assign lvl_now[phyirq_pkg::BIT_NEG_DONE]     = ev.neg_complete;
    assign lvl_now[phyirq_pkg::BIT_REMOTE_FAULT] = ev.remote_fault;
    assign lvl_now[phyirq_pkg::BIT_LINK_DOWN]    = !ev.link_up;
    assign lvl_now[phyirq_pkg::BIT_PARTNER_ACK]  = ev.partner_ack;
    assign lvl_now[phyirq_pkg::BIT_PAR_FAULT]    = ev.par_fault;
    assign lvl_now[phyirq_pkg::BIT_PAGE_RX]      = ev.page_rx;

    assign lvl_old[phyirq_pkg::BIT_NEG_DONE]     = st_r.prev.neg_complete;
    assign lvl_old[phyirq_pkg::BIT_REMOTE_FAULT] = st_r.prev.remote_fault;
    assign lvl_old[phyirq_pkg::BIT_LINK_DOWN]    = !st_r.prev.link_up;
    assign lvl_old[phyirq_pkg::BIT_PARTNER_ACK]  = st_r.prev.partner_ack;
    assign lvl_old[phyirq_pkg::BIT_PAR_FAULT]    = st_r.prev.par_fault;
    assign lvl_old[phyirq_pkg::BIT_PAGE_RX]      = st_r.prev.page_rx;

    // One edge detector per line event
    for (genvar gi = 1; gi <= 6; gi++) begin : g_edge
        assign rise_v[gi] = lvl_now[gi] && !lvl_old[gi];
    end

    // Energy timeout end point
    assign tmo_end = (longint'(st_r.tmo) >= ENERGY_TMO_CYC - 1);

    // Read data mux
    always_comb begin
        rd_v = 16'h0000;
        if (hit_flags) begin
            rd_v[7:1] = st_r.flags;
        end else if (hit_mask) begin
            rd_v[7:0] = st_r.mask;
        end else if (hit_status) begin
            rd_v[phyirq_pkg::BIT_AUTODONE] = st_r.autodone;
            rd_v[phyirq_pkg::KEEP_HI:phyirq_pkg::KEEP_LO] = st_r.keep;
            rd_v[phyirq_pkg::SPD_HI:phyirq_pkg::SPD_LO] = st_r.spd;
        end else begin
            rd_v = 16'h0000;
        end
    end

    always_comb begin
        st_nxt      = st_r;
        set_v       = '0;
        energy_rise = 1'b0;

        // Three-stage sync of the line levels
        st_nxt.s1   = line_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.prev = ev;

        // Energy timer restarts on any valid energy seen
        if (ev.energy_valid) begin
            st_nxt.tmo    = '0;
            st_nxt.energy = 1'b1;
        end else if (st_r.energy) begin
            if (tmo_end) begin
                st_nxt.energy = 1'b0;
            end else begin
                st_nxt.tmo = st_r.tmo + 1'b1;
            end
        end

        energy_rise = st_nxt.energy && !st_r.energy;

        // Rising edges become latched events
        set_v[phyirq_pkg::BIT_ENERGY] = energy_rise;
        set_v[6:1]                    = rise_v;

        // Hold off events until the sync stages hold real line values
        if (st_r.first) begin
            set_v = '0;
            if (st_r.warm != 2'h3) begin
                st_nxt.warm = st_r.warm + 2'h1;
            end else if (settled) begin
                st_nxt.first = 1'b0;
                st_nxt.flags[phyirq_pkg::BIT_LINK_DOWN] =
                    !st_r.s3.link_up;
            end
        end

        st_nxt.autodone = neg_enabled_i && ev.neg_complete;

        if (!st_r.first) begin
            st_nxt.spd = ev.speed_duplex;
        end

        // Bus handshake: one answer cycle, then idle again
        case (st_r.bus)
            phyirq_pkg::BUS_IDLE: begin
                if (req) begin
                    st_nxt.bus = phyirq_pkg::BUS_ACK;
                end
            end
            phyirq_pkg::BUS_ACK: begin
                st_nxt.bus = phyirq_pkg::BUS_IDLE;
            end
            default: begin
                st_nxt.bus = phyirq_pkg::BUS_IDLE;
            end
        endcase

        st_nxt.ack = req;

        // Reading the flags clears them
        if (rd_req && hit_flags) begin
            st_nxt.flags = '0;
        end

        // Only the low mask byte is kept
        if (wr_req && hit_mask && wb_sel_i[0]) begin
            st_nxt.mask = wb_dat_i[7:0];
        end

        if (wr_req && hit_status) begin
            if (wb_sel_i[0]) begin
                st_nxt.keep[2:0] = wb_dat_i[7:5];
            end
            if (wb_sel_i[1]) begin
                st_nxt.keep[6:3] = wb_dat_i[11:8];
            end
        end

        // Set wins over the read clear
        st_nxt.flags = st_nxt.flags | set_v;

        if (req) begin
            st_nxt.dat = {16'h0000, rd_v};
        end else begin
            st_nxt.dat = 32'h0000_0000;
        end

        st_nxt.irq = |(st_nxt.flags & st_nxt.mask[7:1]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= '0;
            st_r.first  <= 1'b1;
            st_r.warm   <= 2'h0;
            st_r.mask   <= phyirq_pkg::MASK_RESET;
            st_r.keep   <= phyirq_pkg::KEEP_RESET;
            st_r.energy <= 1'b1;
            st_r.bus    <= phyirq_pkg::BUS_IDLE;
            st_r.ack    <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state record

    assign wb_dat_o = st_r.dat;

    assign wb_ack_o = st_r.ack;

    assign energy_present_o = st_r.energy;

    assign irq_o = st_r.irq;

endmodule

/* verilog/phyirq_pkg.sv */
package phyirq_pkg;

    // Register indices; byte address is four times the index
    localparam logic [4:0]  IDX_SOURCE_FLAGS = 5'h1D;
    localparam logic [4:0]  IDX_ENABLE_MASK  = 5'h1E;
    localparam logic [4:0]  IDX_NEG_STATUS   = 5'h1F;
    localparam int          ADDR_LSB         = 2;

    // Event flag bit positions
    localparam int          BIT_ENERGY       = 7;
    localparam int          BIT_NEG_DONE     = 6;
    localparam int          BIT_REMOTE_FAULT = 5;
    localparam int          BIT_LINK_DOWN    = 4;
    localparam int          BIT_PARTNER_ACK  = 3;
    localparam int          BIT_PAR_FAULT    = 2;
    localparam int          BIT_PAGE_RX      = 1;
    localparam int          FLAG_HI          = 7;
    localparam int          FLAG_LO          = 1;

    // Status register fields
    localparam int          BIT_AUTODONE     = 12;
    localparam int          KEEP_HI          = 11;
    localparam int          KEEP_LO          = 5;
    localparam int          SPD_HI           = 4;
    localparam int          SPD_LO           = 2;
    localparam logic [6:0]  KEEP_RESET       = 7'h02;
    localparam logic [7:0]  MASK_RESET       = 8'h00;

    // Resolved speed and duplex codes
    localparam logic [2:0]  SPD_10_HALF      = 3'h1;
    localparam logic [2:0]  SPD_10_FULL      = 3'h5;
    localparam logic [2:0]  SPD_100_HALF     = 3'h2;
    localparam logic [2:0]  SPD_100_FULL     = 3'h6;

    // Energy timeout
    localparam int          CLK_HZ           = 125_000_000;
    localparam int          ENERGY_TMO_MS    = 256;
    localparam longint      ENERGY_TMO_CYC   =
        (longint'(ENERGY_TMO_MS) * CLK_HZ) / 1000;

    typedef struct packed {
        logic        energy_valid;
        logic        neg_complete;
        logic        remote_fault;
        logic        link_up;
        logic        partner_ack;
        logic        par_fault;
        logic        page_rx;
        logic [2:0]  speed_duplex;
    } phyirq_events_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } phyirq_bus_t;

endpackage

/* verif/phyirq_line_model.sv */
`timescale 1ns/1ps
// Line side: wanted levels appear one clock later, as from the PHY core
module phyirq_line_model (
    input  wire logic                       clk_i,
    input  wire phyirq_pkg::phyirq_events_t want_i,
    output phyirq_pkg::phyirq_events_t      line_o
);
    always_ff @(posedge clk_i) begin
        line_o <= want_i;
    end
endmodule

/* verif/phyirq_chk.sv */
`timescale 1ns/1ps
module phyirq_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        energy_present_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic rd = wb_ack_o && !wb_we_i;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_taken: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    a_flag_rsvd: assert property (rd && wb_adr_i == 8'h74 |->
        wb_dat_o[31:8] == 24'h0 && !wb_dat_o[0]) else $error("flag bits");
    a_mask_high: assert property (rd && wb_adr_i == 8'h78 |->
        wb_dat_o[31:8] == 24'h0) else $error("mask high byte");
    a_stat_rsvd: assert property (rd && wb_adr_i == 8'h7C |->
        wb_dat_o[15:13] == 3'h0 && wb_dat_o[1:0] == 2'h0)
        else $error("status bits");
    a_irq_reset: assert property ($fell(rst_i) |-> !irq_o)
        else $error("irq after reset");
    a_energy_reset: assert property ($fell(rst_i) |-> energy_present_o)
        else $error("energy after reset");
    cover property (rd && wb_adr_i == 8'h74 && wb_dat_o[7:1] != 7'h0);
    cover property ($rose(irq_o));
    cover property ($fell(energy_present_o));
endmodule

/* verif/phy_interrupt_status_regs_bench.sv */
`timescale 1ns/1ps
module phy_interrupt_status_regs_bench;
    logic                       clk_i = 1'b0;
    logic                       rst_i = 1'b1;
    logic                       cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic                       neg_en = 1'b1, ack, irq, ep;
    logic [7:0]                 adr = 8'h00;
    logic [31:0]                wdat = 32'h0, rdat, q;
    phyirq_pkg::phyirq_events_t want = '0, line;
    int                         bad_count = 0, tests_run = 0;
    always #4 clk_i = ~clk_i;
    phyirq_line_model i_phyirq_line_model (.clk_i(clk_i), .want_i(want),
        .line_o(line));
    phyirq_top #(.ENERGY_TMO_CYC(50)) i_phyirq_top (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .line_i(line),
        .neg_enabled_i(neg_en), .energy_present_o(ep), .irq_o(irq));
    task automatic report_and_stop;
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 16'h0);
        chk(q, e);
    endtask
    function automatic logic [31:0] st(input logic d, input logic [2:0] s);
        return {19'h0, d, 7'h02, s, 2'h0};
    endfunction
    task automatic t_reset;
        rd(8'h74, 32'h10);
        rd(8'h74, 32'h0);
        rd(8'h78, 32'h0);
        rd(8'h7C, st(1'b0, phyirq_pkg::SPD_100_FULL));
        rd(8'h40, 32'h0);
        wb(1'b1, 8'h78, 16'h00FF);
        rd(8'h78, 32'hFF);
    endtask
    task automatic t_speed;
        logic [2:0] c [4];
        c = '{3'h1, 3'h5, 3'h2, 3'h6};
        for (int i = 0; i < 4; i++) begin
            want.speed_duplex <= c[i];
            want.neg_complete <= 1'b1;
            tick(8);
            rd(8'h7C, st(1'b1, c[i]));
        end
        neg_en <= 1'b0;
        tick(2);
        rd(8'h7C, st(1'b0, c[3]));
        wb(1'b1, 8'h7C, 16'h0040);
        rd(8'h7C, st(1'b0, c[3]));
    endtask
    task automatic t_events;
        wb(1'b1, 8'h78, 16'h0);
        want <= '{link_up: 1'b1, energy_valid: 1'b1, default: '0};
        tick(8);
        wb(1'b0, 8'h74, 16'h0);
        want <= '{energy_valid: 1'b1, link_up: 1'b0, speed_duplex: 3'h0,
            default: '1};
        tick(8);
        want <= '{energy_valid: 1'b1, default: '0};
        tick(8);
        chk(irq, 1'b0);
        wb(1'b1, 8'h78, 16'h0020);
        tick(2);
        chk(irq, 1'b1);
        rd(8'h74, 32'h7E);
        tick(2);
        chk(irq, 1'b0);
        rd(8'h74, 32'h0);
    endtask
    task automatic t_energy;
        want.energy_valid <= 1'b0;
        tick(70);
        chk(ep, 1'b0);
        want.energy_valid <= 1'b1;
        tick(8);
        chk(ep, 1'b1);
        rd(8'h74, 32'h80);
    endtask
    initial begin
        want.energy_valid = 1'b1;
        want.speed_duplex = phyirq_pkg::SPD_100_FULL;
        tick(3);
        rst_i <= 1'b0;
        tick(8);
        t_reset;
        t_speed;
        t_events;
        t_energy;
        report_and_stop;
    end
    initial begin
        #100000;
        bad_count++;
        report_and_stop;
    end
endmodule
bind phyirq_top phyirq_chk i_phyirq_chk (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_o,
    .energy_present_o);
